/* core/link_status_gain_control.sv */
// link_status word, demodulator settings and receive gain loop registers
`timescale 1ns/1ps
// Summary of operation
// - two-bit collision threshold, 11 disables detection
// - pre-filter averages four, square shaper reshapes
// - sync bit picks correlation max, default min
// - bit0 selects psk, bit1 fsk always reads zero
// - three-bit sequencer state, reset idle
// - four-bit power gear readback, reset zero
// - pll flag needs field, frequency, lock
// - crc good when zero, or residue when crc inverted
// - own field flag while drivers on
// - foreign field flag from filtered detectors
// - three-bit peer fault cause codes
// - fault code clears when field drive written in a cycle without a fault interrupt
// - decoder ready flag once sequencer enables
// - encoder busy flag while sending
// - decoder busy flag while receiving
// - ten-bit live gain readback
// - gain reference select, reset 10
// - update period is field plus one cycles
// - source bit picks card or reader gain
// - load strobe copies static gain, self-clears
// - fixed source: static value or frozen last
// - tracking bit runs loop, else holds fixed
// - static gain register, reader high, card low
module link_status_gain_control
  import rx_gain_pkg::*;
#(
  parameter int gain_width = 10,
  parameter logic [15:0] crc_residue = 16'h0000
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [9:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire rf_live_t live_in,
  input wire logic field_drive_write_in,
  input wire logic gain_up_in,
  input wire logic gain_down_in,
  output demod_ctl_t demod_out,
  output logic [1:0] gain_reference_pick_out,
  output logic gain_step_out,
  output logic [gain_width-1:0] rx_divider_out
);

  logic [1:0] collision_threshold;
  logic pre_filter_on;
  logic square_shaper_on;
  logic sync_at_max;
  logic psk_on;
  logic [1:0] gain_reference_pick;
  logic [9:0] gain_update_period;
  logic static_gain_source;
  logic gain_load_strobe;
  logic fixed_gain_source;
  logic gain_tracking_on;
  logic [gain_width-1:0] reader_static_gain;
  logic [gain_width-1:0] card_static_gain;
  logic [gain_width-1:0] gain_setting_now;
  logic [9:0] period_count;
  logic [2:0] peer_mode_fault_code;
  logic [31:0] status_word;
  logic [gain_width-1:0] static_pick;
  logic wr_demod;
  logic wr_gain;
  logic wr_static;
  logic crc_good;

  assign wr_demod = clk_en_in && wr_in && addr_in == demod_config_addr;
  assign wr_gain = clk_en_in && wr_in && addr_in == gain_loop_config_addr;
  assign wr_static = clk_en_in && wr_in && addr_in == static_gain_addr;

  // demodulator configuration
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      collision_threshold <= coll_reset;
      pre_filter_on <= 1'b0;
      square_shaper_on <= 1'b0;
      sync_at_max <= 1'b0;
      psk_on <= 1'b0;
    end else if (wr_demod) begin
      collision_threshold <= wdata_in[coll_lsb +: 2];
      pre_filter_on <= wdata_in[pre_filter_bit];
      square_shaper_on <= wdata_in[square_bit];
      sync_at_max <= wdata_in[sync_bit];
      psk_on <= wdata_in[psk_bit];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      demod_out <= '0;
      // threshold code 00 after reset still means detection is on
      demod_out.collision_detect_on <= 1'b1;
    end else if (clk_en_in) begin
      demod_out.collision_threshold <= collision_threshold;
      demod_out.collision_detect_on <= collision_threshold != coll_off;
      demod_out.pre_filter_on <= pre_filter_on;
      demod_out.square_shaper_on <= square_shaper_on;
      demod_out.sync_at_max <= sync_at_max;
      demod_out.psk_on <= psk_on;
    end
  end

  // gain loop configuration; load strobe lives one cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gain_reference_pick <= vref_reset;
      gain_update_period <= period_reset;
      static_gain_source <= 1'b0;
      gain_load_strobe <= 1'b0;
      fixed_gain_source <= 1'b1;
      gain_tracking_on <= 1'b1;
    end else if (clk_en_in) begin
      gain_load_strobe <= wr_gain && wdata_in[load_bit];
      if (wr_gain) begin
        gain_reference_pick <= wdata_in[vref_lsb +: 2];
        gain_update_period <= wdata_in[period_lsb +: 10];
        static_gain_source <= wdata_in[source_bit];
        fixed_gain_source <= wdata_in[fixed_src_bit];
        gain_tracking_on <= wdata_in[tracking_bit];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reader_static_gain <= '0;
      card_static_gain <= '0;
    end else if (wr_static) begin
      reader_static_gain <= wdata_in[reader_gain_lsb +: gain_width];
      card_static_gain <= wdata_in[card_gain_lsb +: gain_width];
    end
  end

  assign static_pick = static_gain_source ? reader_static_gain
                                          : card_static_gain;

  // update period counter: a step every field+1 cycles
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      period_count <= '0;
      gain_step_out <= 1'b0;
    end else if (clk_en_in) begin
      gain_step_out <= 1'b0;
      if (!gain_tracking_on || period_count >= gain_update_period) begin
        period_count <= '0;
        gain_step_out <= gain_tracking_on;
      end else begin
        period_count <= period_count + 10'h001;
      end
    end
  end

  // receive divider: load strobe, tracking, fixed static or frozen
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gain_setting_now <= '0;
    end else if (clk_en_in) begin
      if (gain_load_strobe) begin
        gain_setting_now <= static_pick;
      end else if (gain_tracking_on) begin
        if (gain_step_out && gain_up_in && !(&gain_setting_now)) begin
          gain_setting_now <= gain_setting_now + 1'b1;
        end else if (gain_step_out && gain_down_in &&
                     |gain_setting_now) begin
          gain_setting_now <= gain_setting_now - 1'b1;
        end
      end else if (!fixed_gain_source) begin
        gain_setting_now <= static_pick;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_divider_out <= '0;
      gain_reference_pick_out <= vref_reset;
    end else if (clk_en_in) begin
      rx_divider_out <= gain_setting_now;
      gain_reference_pick_out <= gain_reference_pick;
    end
  end

  // fault cause: latched with the interrupt, which wins over the clear by field drive write
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      peer_mode_fault_code <= fault_none;
    end else if (clk_en_in) begin
      if (live_in.peer_mode_fault_irq) begin
        peer_mode_fault_code <= live_in.peer_mode_fault_code;
      end else if (field_drive_write_in) begin
        peer_mode_fault_code <= fault_none;
      end
    end
  end

  assign crc_good = live_in.crc_inverted ? live_in.crc_value == crc_residue
                                         : live_in.crc_value == 16'h0000;

  always_comb begin
    status_word = '0;
    status_word[seq_lsb +: 3] = live_in.seq_state;
    status_word[gear_lsb +: 4] = live_in.power_gear_now;
    status_word[pll_bit] = live_in.field_present && live_in.freq_valid &&
                           live_in.pll_locked;
    status_word[crc_bit] = crc_good;
    status_word[own_bit] = live_in.drivers_on;
    status_word[foreign_bit] = live_in.foreign_field_seen;
    status_word[fault_lsb +: 3] = peer_mode_fault_code;
    status_word[dec_ready_bit] = live_in.decoder_enabled &&
                                 live_in.decoder_ready;
    status_word[enc_busy_bit] = live_in.encoder_busy;
    status_word[dec_busy_bit] = live_in.decoder_busy;
    status_word[0 +: gain_width] = gain_setting_now;
  end

  // read data one cycle after the read strobe
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= '0;
    end else if (clk_en_in) begin
      rdata_out <= '0;
      if (rd_in) begin
        unique case (addr_in)
          demod_config_addr: begin
            rdata_out[coll_lsb +: 2] <= collision_threshold;
            rdata_out[pre_filter_bit] <= pre_filter_on;
            rdata_out[square_bit] <= square_shaper_on;
            rdata_out[sync_bit] <= sync_at_max;
            rdata_out[fsk_bit] <= 1'b0;
            rdata_out[psk_bit] <= psk_on;
          end
          link_status_addr: begin
            rdata_out <= status_word;
          end
          gain_loop_config_addr: begin
            rdata_out[vref_lsb +: 2] <= gain_reference_pick;
            rdata_out[period_lsb +: 10] <= gain_update_period;
            rdata_out[source_bit] <= static_gain_source;
            rdata_out[fixed_src_bit] <= fixed_gain_source;
            rdata_out[tracking_bit] <= gain_tracking_on;
          end
          static_gain_addr: begin
            rdata_out[reader_gain_lsb +: gain_width] <= reader_static_gain;
            rdata_out[card_gain_lsb +: gain_width] <= card_static_gain;
          end
          default: begin
            rdata_out <= '0;
          end
        endcase
      end
    end
  end

  property p_load_copies;
    @(posedge clk_in) disable iff (reset_in)
    clk_en_in && gain_load_strobe |=> gain_setting_now == $past(static_pick);
  endproperty
  a_load_copies: assert property (p_load_copies)
    else $error("load strobe did not copy static gain");

  property p_strobe_clears;
    @(posedge clk_in) disable iff (reset_in)
    clk_en_in && gain_load_strobe && !wr_gain |=> !gain_load_strobe;
  endproperty
  a_strobe_clears: assert property (p_strobe_clears)
    else $error("load strobe did not clear");

  property p_frozen;
    @(posedge clk_in) disable iff (reset_in)
    clk_en_in && !gain_tracking_on && fixed_gain_source && !gain_load_strobe
      |=> $stable(gain_setting_now);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("frozen gain changed");

  property p_fixed_static;
    @(posedge clk_in) disable iff (reset_in)
    clk_en_in && !gain_tracking_on && !fixed_gain_source
      |=> gain_setting_now == $past(static_pick);
  endproperty
  a_fixed_static: assert property (p_fixed_static)
    else $error("fixed mode did not use static gain");

  sequence s_step;
    clk_en_in && gain_step_out;
  endsequence
  property p_period;
    @(posedge clk_in) disable iff (reset_in)
    s_step ##1 clk_en_in && gain_tracking_on
      |-> period_count == 10'h001 || !clk_en_in;
  endproperty
  a_period: assert property (p_period)
    else $error("period count did not restart");

  property p_fault_clear;
    @(posedge clk_in) disable iff (reset_in)
    clk_en_in && field_drive_write_in && !live_in.peer_mode_fault_irq
      |=> peer_mode_fault_code == fault_none;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault code not cleared");

  property p_status_read;
    @(posedge clk_in) disable iff (reset_in)
    clk_en_in && rd_in && addr_in == link_status_addr
      |=> rdata_out[31:27] == 5'h00 && rdata_out[pll_bit] ==
          ($past(live_in.field_present) && $past(live_in.freq_valid) &&
           $past(live_in.pll_locked));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");

  property p_fsk_zero;
    @(posedge clk_in) disable iff (reset_in)
    clk_en_in && rd_in && addr_in == demod_config_addr
      |=> rdata_out[fsk_bit] == 1'b0;
  endproperty
  a_fsk_zero: assert property (p_fsk_zero)
    else $error("fsk bit not zero");

  property p_coll;
    @(posedge clk_in) disable iff (reset_in)
    clk_en_in ##1 clk_en_in |->
      demod_out.collision_detect_on == ($past(collision_threshold) != coll_off);
  endproperty
  a_coll: assert property (p_coll)
    else $error("collision enable wrong");

  property p_rdata_idle;
    @(posedge clk_in) disable iff (reset_in)
    !reset_in && clk_en_in && !rd_in |=> rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not idle");

  property p_vref_out;
    @(posedge clk_in) disable iff (reset_in)
    !reset_in && clk_en_in
      |=> gain_reference_pick_out == $past(gain_reference_pick);
  endproperty
  a_vref_out: assert property (p_vref_out)
    else $error("reference pick output wrong");

  property p_step_tracking;
    @(posedge clk_in) disable iff (reset_in)
    !reset_in && clk_en_in && !gain_tracking_on |=> !gain_step_out;
  endproperty
  a_step_tracking: assert property (p_step_tracking)
    else $error("gain step while tracking off");

  property p_fault_latch;
    @(posedge clk_in) disable iff (reset_in)
    !reset_in && clk_en_in && live_in.peer_mode_fault_irq
      |=> peer_mode_fault_code == $past(live_in.peer_mode_fault_code);
  endproperty
  a_fault_latch: assert property (p_fault_latch)
    else $error("fault code not latched");

  property p_crc_read;
    @(posedge clk_in) disable iff (reset_in)
    !reset_in && clk_en_in && rd_in && addr_in == link_status_addr
      |=> rdata_out[crc_bit] == ($past(live_in.crc_inverted) ?
          $past(live_in.crc_value) == crc_residue :
          $past(live_in.crc_value) == 16'h0000);
  endproperty
  a_crc_read: assert property (p_crc_read)
    else $error("crc good flag wrong");

  // one tracking step upward, away from the top of the range
  sequence s_up_step;
    !reset_in && clk_en_in && gain_tracking_on && !gain_load_strobe &&
      gain_step_out && gain_up_in && !(&gain_setting_now);
  endsequence
  property p_track_up;
    @(posedge clk_in) disable iff (reset_in)
    s_up_step |=> gain_setting_now == $past(gain_setting_now) + 1'b1;
  endproperty
  a_track_up: assert property (p_track_up)
    else $error("tracking step up missed");

endmodule

/* core/rx_gain_pkg.sv */
// package: register map, field layouts and reset values of the receive path
package rx_gain_pkg;
  // register indices and byte addresses
  localparam logic [7:0] demod_config_idx = 8'h1c;
  localparam logic [7:0] link_status_idx = 8'h1d;
  localparam logic [7:0] gain_loop_config_idx = 8'h1e;
  localparam logic [7:0] static_gain_idx = 8'h1f;
  localparam logic [9:0] demod_config_addr = {demod_config_idx, 2'h0};
  localparam logic [9:0] link_status_addr = {link_status_idx, 2'h0};
  localparam logic [9:0] gain_loop_config_addr =
    {gain_loop_config_idx, 2'h0};
  localparam logic [9:0] static_gain_addr = {static_gain_idx, 2'h0};

  // demod_config field positions
  localparam int coll_lsb = 5;
  localparam int pre_filter_bit = 4;
  localparam int square_bit = 3;
  localparam int sync_bit = 2;
  localparam int fsk_bit = 1;
  localparam int psk_bit = 0;
  localparam logic [1:0] coll_reset = 2'h0;
  localparam logic [1:0] coll_off = 2'h3;

  // gain_loop_config field positions and reset values
  localparam int vref_lsb = 14;
  localparam int period_lsb = 4;
  localparam int source_bit = 3;
  localparam int load_bit = 2;
  localparam int fixed_src_bit = 1;
  localparam int tracking_bit = 0;
  localparam logic [1:0] vref_reset = 2'h2;
  localparam logic [9:0] period_reset = 10'h200;
  localparam logic [9:0] period_min = 10'h004;

  // static gain field positions
  localparam int reader_gain_lsb = 10;
  localparam int card_gain_lsb = 0;

  // link_status field positions
  localparam int seq_lsb = 24;
  localparam int gear_lsb = 20;
  localparam int pll_bit = 19;
  localparam int crc_bit = 18;
  localparam int own_bit = 17;
  localparam int foreign_bit = 16;
  localparam int fault_lsb = 13;
  localparam int dec_ready_bit = 12;
  localparam int enc_busy_bit = 11;
  localparam int dec_busy_bit = 10;

  typedef enum logic [2:0] {
    seq_idle = 3'h0,
    seq_wait_tx = 3'h1,
    seq_tx = 3'h2,
    seq_wait_rx = 3'h3,
    seq_wait_data = 3'h4,
    seq_rx = 3'h5,
    seq_loopback = 3'h6
  } seq_state_t;

  typedef enum logic [2:0] {
    fault_none = 3'h0,
    fault_field_initial = 3'h1,
    fault_field_active = 3'h2,
    fault_no_field = 3'h3,
    fault_peer_off = 3'h4
  } fault_code_t;

  // live status from the surrounding receive and transmit logic
  typedef struct packed {
    logic [2:0] seq_state;
    logic [3:0] power_gear_now;
    logic field_present;
    logic freq_valid;
    logic pll_locked;
    logic [15:0] crc_value;
    logic crc_inverted;
    logic drivers_on;
    logic foreign_field_seen;
    logic peer_mode_fault_irq;
    logic [2:0] peer_mode_fault_code;
    logic decoder_enabled;
    logic decoder_ready;
    logic encoder_busy;
    logic decoder_busy;
  } rf_live_t;

  // settings that steer the demodulator
  typedef struct packed {
    logic [1:0] collision_threshold;
    logic pre_filter_on;
    logic square_shaper_on;
    logic sync_at_max;
    logic psk_on;
    logic collision_detect_on;
  } demod_ctl_t;
endpackage

/* dv/link_status_gain_control_bench.sv */
// self-checking bench for the link_status and gain loop registers
`timescale 1ns/1ps
module link_status_gain_control_bench;
  import rx_gain_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [9:0] addr_in = 10'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  rf_live_t live_in = '0;
  logic field_drive_write_in = 1'b0;
  logic gain_up_in = 1'b0;
  logic gain_down_in = 1'b0;
  demod_ctl_t demod_out;
  logic [1:0] gain_reference_pick_out;
  logic gain_step_out;
  logic [9:0] rx_divider_out;
  logic [31:0] seed = 32'hbda2d51f;
  logic [31:0] rd;
  logic [31:0] w;
  logic [9:0] r1;
  logic [9:0] c1;
  logic [9:0] d1;
  logic [2:0] code;
  rf_live_t l;
  int bad_count = 0;
  int checked = 0;
  int k;
  // residue value for the inverted crc check, value arbitrary
  localparam logic [15:0] crc_res = 16'h5a3c;
  always #50 clk_in = ~clk_in;
  link_status_gain_control #(.crc_residue(crc_res)) u_dut (.clk_in(clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .live_in(live_in), .field_drive_write_in(field_drive_write_in),
    .gain_up_in(gain_up_in), .gain_down_in(gain_down_in),
    .demod_out(demod_out),
    .gain_reference_pick_out(gain_reference_pick_out),
    .gain_step_out(gain_step_out), .rx_divider_out(rx_divider_out));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] status_exp(input rf_live_t v,
      input logic [2:0] c, input logic [9:0] g);
    logic [31:0] s;
    s = 32'h0;
    s[26:24] = v.seq_state;
    s[23:20] = v.power_gear_now;
    s[19] = v.field_present & v.freq_valid & v.pll_locked;
    s[18] = v.crc_inverted ? v.crc_value == crc_res : v.crc_value == 16'h0;
    s[17] = v.drivers_on;
    s[16] = v.foreign_field_seen;
    s[15:13] = c;
    s[12] = v.decoder_enabled & v.decoder_ready;
    s[11] = v.encoder_busy;
    s[10] = v.decoder_busy;
    s[9:0] = g;
    return s;
  endfunction
  function automatic logic [31:0] demod_ctl_exp(input logic [31:0] v);
    return {25'h0, v[6:5], v[4:2], v[0], v[6:5] != 2'h3};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic bus_rd(input logic [9:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    rd = rdata_out;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // returns the cycles waited until the next gain step pulse
  task automatic wait_step(output int n);
    for (n = 1; n <= 2000; n++) begin
      @(posedge clk_in);
      #1;
      if (gain_step_out === 1'b1) begin
        return;
      end
    end
    $display("CHECK FAILED gain_step expected 1 seen 0");
    bad_count++;
    finish_test();
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    bus_rd(demod_config_addr);
    chk("demod reset", 32'h0, rd);
    bus_rd(gain_loop_config_addr);
    chk("gain cfg reset", 32'h0000a003, rd);
    chk("rdata stands", 32'h0000a003, rdata_out);
    cyc(1);
    chk("rdata one cycle", 32'h0, rdata_out);
    bus_rd(static_gain_addr);
    chk("static reset", 32'h0, rd);
    bus_rd(link_status_addr);
    chk("status reset", status_exp(live_in, 3'h0, 10'h0), rd);
    chk("vref out reset", 32'h2, {30'h0, gain_reference_pick_out});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      w = seed;
      w[6:5] = i[1:0];
      bus_wr(demod_config_addr, w);
      bus_rd(demod_config_addr);
      chk("demod rb", {25'h0, w[6:2], 1'b0, w[0]}, rd);
      chk("demod out", demod_ctl_exp(w), {25'h0, demod_out});
    end
    clk_en_in <= 1'b0;
    bus_wr(demod_config_addr, ~w);
    clk_en_in <= 1'b1;
    bus_rd(demod_config_addr);
    chk("demod frozen", {25'h0, w[6:2], 1'b0, w[0]}, rd);
    bus_rd(10'h3fc);
    chk("unmapped", 32'h0, rd);
    $display("test demod done");
    code = 3'h0;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      l = rf_live_t'({seed, seed[4:0]});
      l.seq_state = seed[2:0] % 3'h7;
      l.peer_mode_fault_code = seed[10:8] % 3'h5;
      l.crc_value = seed[3] ? (seed[12] ? crc_res : 16'h0) : seed[31:16];
      if (l.peer_mode_fault_irq) begin
        code = l.peer_mode_fault_code;
      end
      live_in <= l;
      bus_wr(link_status_addr, ~seed);
      bus_rd(link_status_addr);
      chk("status", status_exp(l, code, 10'h0), rd);
    end
    l.peer_mode_fault_irq = 1'b1;
    l.peer_mode_fault_code = 3'h3;
    live_in <= l;
    cyc(2);
    l.peer_mode_fault_irq = 1'b0;
    live_in <= l;
    bus_rd(link_status_addr);
    chk("fault held", status_exp(l, 3'h3, 10'h0), rd);
    field_drive_write_in <= 1'b1;
    @(posedge clk_in);
    field_drive_write_in <= 1'b0;
    bus_rd(link_status_addr);
    chk("fault clear", status_exp(l, 3'h0, 10'h0), rd);
    $display("test status done");
    seed = lfsr(seed);
    r1 = seed[19:10];
    c1 = seed[9:0];
    bus_wr(static_gain_addr, seed);
    bus_rd(static_gain_addr);
    chk("static rb", {12'h0, r1, c1}, rd);
    w = {seed[31:16], seed[15:14], 10'h4, 4'h6};
    bus_wr(gain_loop_config_addr, w);
    cyc(3);
    chk("load card", {22'h0, c1}, {22'h0, rx_divider_out});
    bus_rd(gain_loop_config_addr);
    chk("cfg rb", w & 32'h0000fffb, rd);
    chk("vref out", {30'h0, w[15:14]}, {30'h0, gain_reference_pick_out});
    bus_rd(link_status_addr);
    chk("gain field", status_exp(l, 3'h0, c1), rd);
    gain_up_in <= 1'b1;
    cyc(20);
    chk("frozen", {22'h0, c1}, {22'h0, rx_divider_out});
    bus_wr(gain_loop_config_addr, 32'h0000804e);
    cyc(3);
    chk("load reader", {22'h0, r1}, {22'h0, rx_divider_out});
    bus_wr(gain_loop_config_addr, 32'h00008040);
    cyc(3);
    chk("fixed card", {22'h0, c1}, {22'h0, rx_divider_out});
    bus_wr(static_gain_addr, {22'h0, ~c1});
    cyc(3);
    chk("fixed follows", {22'h0, ~c1}, {22'h0, rx_divider_out});
    $display("test fixed done");
    bus_wr(static_gain_addr, 32'h00000100);
    for (int p = 4; p < 14; p += 5) begin
      bus_wr(gain_loop_config_addr, {18'h0, p[9:0], 4'h5});
      wait_step(k);
      wait_step(k);
      chk("step period", p + 1, k);
    end
    for (int dir = 0; dir < 2; dir++) begin
      gain_up_in <= (dir == 0);
      gain_down_in <= (dir == 1);
      wait_step(k);
      cyc(2);
      d1 = rx_divider_out;
      wait_step(k);
      cyc(2);
      chk("track", {22'h0, dir == 0 ? d1 + 10'h1 : d1 - 10'h1},
        {22'h0, rx_divider_out});
    end
    $display("test tracking done");
    finish_test();
  end
endmodule
